// ---- sdl_ctrl.sv ----
// Controller end: AXI4-Lite command registers driving the servo pins
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module sdl_ctrl
  import sdl_pkg::*;
#(
  parameter int WAIT_CYC = SDL_WAIT_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  sdl_link_if.ctrl LINK,
  input wire logic [3:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [3:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);
  if (WAIT_CYC < 1 || WAIT_CYC > 65535) begin : g_bad_wait
    $error("WAIT_CYC out of range");
  end

  sdl_state_t st_q;
  logic [15:0] cnt_q;
  logic [7:0] word_q;
  logic dir_q, seek_q, ref_q, ready_q;
  logic [1:0] div_q;
  logic aw_q, w_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [2:0] tr_s1, tr_s2, tr_s3, tr_q;
  logic do_wr;
  logic open_d;

  ////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign do_wr = aw_q && w_q && !O_BVALID;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= SDL_ADDR_CMD;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= SDL_RESP_OK;
    end else begin
      O_AWREADY <= !aw_q && !O_AWREADY && !(I_AWVALID && O_AWREADY);
      O_WREADY <= !w_q && !O_WREADY && !(I_WVALID && O_WREADY);
      if (I_AWVALID && O_AWREADY) begin
        aw_q <= 1'b1;
        awaddr_q <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= (awaddr_q == SDL_ADDR_CMD) ? SDL_RESP_OK : SDL_RESP_ERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Command register: word, direction, mode
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      word_q <= SDL_WORD_ZERO;
      dir_q <= SDL_DIR_UP;
      seek_q <= SDL_MODE_SEEK;
    end else if (do_wr && awaddr_q == SDL_ADDR_CMD) begin
      if (wstrb_q[0]) word_q <= wdata_q[7:0];
      if (wstrb_q[1]) begin
        dir_q <= wdata_q[SDL_CMD_DIR_BIT];
        seek_q <= wdata_q[SDL_CMD_MODE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Latch sequencing and settling wait
  // Word reaches the pins one cycle before the enable opens
  assign open_d = (st_q == SDL_OPEN) && (cnt_q <= SDL_LATCH_CYC);

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      st_q <= SDL_IDLE;
      cnt_q <= 16'h0;
      ready_q <= 1'b0;
    end else begin
      case (st_q)
        SDL_IDLE: begin
          if (do_wr && awaddr_q == SDL_ADDR_CMD && wstrb_q[0]) begin
            st_q <= SDL_OPEN;
            cnt_q <= SDL_LATCH_CYC + 16'h1;
            ready_q <= 1'b0;
          end
        end
        SDL_OPEN: begin
          if (cnt_q == 16'h1) begin
            st_q <= SDL_WAIT;
            cnt_q <= WAIT_CYC[15:0];
          end else begin
            cnt_q <= cnt_q - 16'h1;
          end
        end
        SDL_WAIT: begin
          if (cnt_q == 16'h1) begin
            st_q <= SDL_IDLE;
            ready_q <= 1'b1;
          end
          cnt_q <= cnt_q - 16'h1;
        end
        default: st_q <= SDL_IDLE;
      endcase
    end
  end

  // Reference clock divider, runs from reset on
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      div_q <= 2'h0;
      ref_q <= 1'b0;
    end else if (div_q == 2'(SDL_REF_DIV / 2 - 1)) begin
      div_q <= 2'h0;
      ref_q <= !ref_q;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      LINK.word <= SDL_WORD_ZERO;
      LINK.latch_en <= 1'b0;
      LINK.dir_up <= SDL_DIR_UP;
      LINK.seek <= SDL_MODE_SEEK;
      LINK.ref_clk <= 1'b0;
    end else begin
      if (!open_d) LINK.word <= word_q;
      LINK.latch_en <= open_d;
      LINK.dir_up <= dir_q;
      LINK.seek <= seek_q;
      LINK.ref_clk <= ref_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Track pins in, read channel
  always_ff @(posedge I_CLK) begin
    tr_s1 <= {LINK.track_upper, LINK.track_middle, LINK.track_fine};
    tr_s2 <= tr_s1;
    tr_s3 <= tr_s2;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      tr_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (tr_s2[i] == tr_s3[i]) tr_q[i] <= tr_s3[i];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= SDL_RESP_OK;
    end else begin
      O_ARREADY <= !O_RVALID && !O_ARREADY;
      if (I_ARVALID && O_ARREADY) begin
        O_ARREADY <= 1'b0;
        O_RVALID <= 1'b1;
        O_RRESP <= SDL_RESP_OK;
        O_RDATA <= 32'h0;
        if (I_ARADDR == SDL_ADDR_CMD) begin
          O_RDATA <= {22'h0, seek_q, dir_q, word_q};
        end else if (I_ARADDR == SDL_ADDR_STAT) begin
          O_RDATA <= {27'h0, ready_q, st_q == SDL_IDLE, tr_q[2], tr_q[1], tr_q[0]};
        end else begin
          O_RRESP <= SDL_RESP_ERR;
        end
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sdl_pkg.sv ----
// Package: constants and types for the servo latch and track-crossing link
package sdl_pkg;
  localparam int SDL_WORD_W = 8;
  localparam logic [7:0] SDL_WORD_ZERO = 8'h00;
  localparam logic SDL_MODE_SEEK = 1'h1;
  localparam logic SDL_MODE_FOLLOW = 1'h0;
  localparam logic SDL_DIR_UP = 1'h1;
  localparam int SDL_CLK_MHZ = 10;
  localparam int SDL_REF_MAX_KHZ = 4000;
  localparam int SDL_SETTLE_NS = 5000;
  localparam int SDL_SETTLE_REF_PERIODS = 32;
  localparam int SDL_SETTLE_CYC = (SDL_SETTLE_NS * SDL_CLK_MHZ + 999) / 1000;
  // Even divider keeps the reference square and at or under its ceiling
  localparam int SDL_REF_DIV =
    2 * ((SDL_CLK_MHZ * 1000 + 2 * SDL_REF_MAX_KHZ - 1) / (2 * SDL_REF_MAX_KHZ));
  localparam int SDL_REF_CYC = SDL_SETTLE_REF_PERIODS * SDL_REF_DIV;
  localparam int SDL_WAIT_CYC = SDL_SETTLE_CYC + SDL_REF_CYC;
  // Enable high time, long enough to pass the far end's pin filter
  localparam logic [15:0] SDL_LATCH_CYC = 16'h3;
  localparam logic [1:0] SDL_SEL_N = 2'h0;
  localparam logic [1:0] SDL_SEL_NB = 2'h1;
  localparam logic [1:0] SDL_SEL_Q = 2'h2;
  localparam logic [1:0] SDL_SEL_QB = 2'h3;
  localparam logic [3:0] SDL_ADDR_CMD = 4'h0;
  localparam logic [3:0] SDL_ADDR_STAT = 4'h4;
  localparam int SDL_CMD_DIR_BIT = 8;
  localparam int SDL_CMD_MODE_BIT = 9;
  localparam logic [1:0] SDL_RESP_OK = 2'h0;
  localparam logic [1:0] SDL_RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    SDL_IDLE = 3'b001,
    SDL_OPEN = 3'b010,
    SDL_WAIT = 3'b100
  } sdl_state_t;
endpackage

// ---- sdl_link_if.sv ----
// Interface: pins between the servo device and its controller
`timescale 1ns/100ps
`default_nettype none
interface sdl_link_if;
  logic [7:0] word;
  logic latch_en;
  logic dir_up;
  logic seek;
  logic ref_clk;
  logic sign_n;
  logic sign_q;
  logic sign_nq;
  logic sign_nbq;
  logic track_fine;
  logic track_middle;
  logic track_upper;
  modport device (input word, latch_en, dir_up, seek, ref_clk, sign_n, sign_q, sign_nq,
    sign_nbq, output track_fine, track_middle, track_upper);
  modport ctrl (output word, latch_en, dir_up, seek, ref_clk, input track_fine,
    track_middle, track_upper);
endinterface
`default_nettype wire

// ---- sdl_device.sv ----
// Device end: command latch, converter code, mode steering, track crossings
`timescale 1ns/100ps
`default_nettype none
module sdl_device
  import sdl_pkg::*;
#(
  parameter bit DIVIDER_VARIANT = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  sdl_link_if.device LINK,
  output logic [8:0] O_DAC_CODE,
  output logic O_SWITCH_CLOSED,
  output logic O_INTEGRATOR_CLAMP,
  output logic [1:0] O_POS_SEL,
  output logic O_POS_HELD
);
  logic [7:0] word_q;
  logic [7:0] w0_q, w1_q, w2_q, word_s;
  logic [2:0] sn_q, sq_q, snq_q, snbq_q;
  logic [2:0] seek_q, le_q, dir_q;
  logic n_q, q_q, nq_q, nbq_q, seek_s, le_s, dir_s;
  logic [1:0] sel_d, sel_q;
  logic fine_d, mid_d, up_d;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers, change taken when stages two and three agree
  always_ff @(posedge I_CLK) begin
    sn_q <= {sn_q[1:0], LINK.sign_n};
    sq_q <= {sq_q[1:0], LINK.sign_q};
    snq_q <= {snq_q[1:0], LINK.sign_nq};
    snbq_q <= {snbq_q[1:0], LINK.sign_nbq};
    seek_q <= {seek_q[1:0], LINK.seek};
    le_q <= {le_q[1:0], LINK.latch_en};
    dir_q <= {dir_q[1:0], LINK.dir_up};
    w0_q <= LINK.word;
    w1_q <= w0_q;
    w2_q <= w1_q;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      n_q <= 1'b0;
      q_q <= 1'b0;
      nq_q <= 1'b0;
      nbq_q <= 1'b0;
      seek_s <= SDL_MODE_SEEK;
      le_s <= 1'b0;
      dir_s <= SDL_DIR_UP;
      word_s <= SDL_WORD_ZERO;
    end else begin
      if (sn_q[1] == sn_q[2]) n_q <= sn_q[2];
      if (sq_q[1] == sq_q[2]) q_q <= sq_q[2];
      if (snq_q[1] == snq_q[2]) nq_q <= snq_q[2];
      if (snbq_q[1] == snbq_q[2]) nbq_q <= snbq_q[2];
      if (seek_q[1] == seek_q[2]) seek_s <= seek_q[2];
      if (le_q[1] == le_q[2]) le_s <= le_q[2];
      if (dir_q[1] == dir_q[2]) dir_s <= dir_q[2];
      for (int i = 0; i < SDL_WORD_W; i++) begin
        if (w1_q[i] == w2_q[i]) word_s[i] <= w2_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command word latch: transparent while enabled, frozen when low
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      word_q <= SDL_WORD_ZERO;
    end else if (le_s) begin
      // Word and enable share the filter delay, so capture lines up
      word_q <= word_s;
    end
  end

  // Signed code: zero word is reference, sign bit is direction
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_DAC_CODE <= {1'b0, SDL_WORD_ZERO};
    end else if (word_q == SDL_WORD_ZERO) begin
      O_DAC_CODE <= {1'b0, SDL_WORD_ZERO};
    end else begin
      O_DAC_CODE <= {dir_s == SDL_DIR_UP, word_q};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode steering of switch, integrator and position selection
  always_comb begin
    if (!n_q && !q_q) sel_d = SDL_SEL_N;
    else if (!n_q && q_q) sel_d = SDL_SEL_Q;
    else if (n_q && q_q) sel_d = SDL_SEL_NB;
    else sel_d = SDL_SEL_QB;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_SWITCH_CLOSED <= 1'b0;
      O_INTEGRATOR_CLAMP <= 1'b0;
      O_POS_HELD <= 1'b0;
    end else begin
      O_SWITCH_CLOSED <= (seek_s == SDL_MODE_FOLLOW);
      O_INTEGRATOR_CLAMP <= (seek_s == SDL_MODE_FOLLOW);
      O_POS_HELD <= (seek_s == SDL_MODE_FOLLOW);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      sel_q <= SDL_SEL_N;
    end else if (seek_s == SDL_MODE_SEEK) begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_POS_SEL <= SDL_SEL_N;
    end else begin
      O_POS_SEL <= sel_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Track crossings from sign bits alone
  always_comb begin
    fine_d = n_q ^ q_q ^ nq_q ^ nbq_q;
    if (DIVIDER_VARIANT) begin
      up_d = n_q ^ q_q;
      mid_d = n_q ^ q_q ^ nq_q;
    end else begin
      up_d = nq_q;
      mid_d = nbq_q;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      LINK.track_fine <= 1'b0;
      LINK.track_middle <= 1'b0;
      LINK.track_upper <= 1'b0;
    end else begin
      LINK.track_fine <= fine_d;
      LINK.track_middle <= mid_d;
      LINK.track_upper <= up_d;
    end
  end
endmodule
`default_nettype wire

// ---- sdl_link_properties.sv ----
// Checker: timing relations on the servo link pins
`timescale 1ns/100ps
`default_nettype none
module sdl_link_properties #(
  parameter bit DIVIDER_VARIANT = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [7:0] word,
  input wire logic latch_en,
  input wire logic dir_up,
  input wire logic seek,
  input wire logic ref_clk,
  input wire logic sign_n,
  input wire logic sign_q,
  input wire logic sign_nq,
  input wire logic sign_nbq,
  input wire logic track_fine,
  input wire logic track_middle,
  input wire logic track_upper
);
  wire logic [3:0] sg = {sign_n, sign_q, sign_nq, sign_nbq};
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  a_fine_xor: assert property ($stable(sg)[*8] |-> track_fine == ^sg)
    else $error("fine track output wrong");
  a_upper_cmp: assert property ($stable(sg)[*8] |->
    track_upper == (DIVIDER_VARIANT ? sign_n ^ sign_q : sign_nq))
    else $error("upper track output wrong");
  a_middle_cmp: assert property ($stable(sg)[*8] |->
    track_middle == (DIVIDER_VARIANT ? sign_n ^ sign_q ^ sign_nq : sign_nbq))
    else $error("middle track output wrong");
  a_tracks_quiet: assert property ($stable(sg)[*8] |->
    $stable({track_fine, track_middle, track_upper}))
    else $error("track outputs move with steady inputs");
  a_ref_period: assert property ($rose(ref_clk) |->
    ##1 ref_clk ##1 !ref_clk[*2] ##1 ref_clk)
    else $error("reference clock period wrong");
  a_latch_pulse: assert property ($rose(latch_en) |-> latch_en[*3] ##1 !latch_en)
    else $error("latch enable pulse length wrong");
  a_word_steady: assert property (latch_en |-> $stable(word))
    else $error("word moves while latch open");
  a_reset_mode: assert property ($fell(I_RESET) |-> seek && dir_up && !latch_en)
    else $error("mode pins wrong after reset");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Testbench: controller and device joined over the servo link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sdl_pkg::*;
  logic clk, rst, awv, wv, br, arv, rr;
  logic [3:0] awa, ara, sg, ws;
  logic [31:0] wd, rd_q;
  logic [1:0] rsp;
  logic [31:0] cmds [5] = '{32'h3A5, 32'h201, 32'h180, 32'h000, 32'h3FF};
  wire logic awr, wr_r, bv, arr, rv, sw, clamp, held;
  wire logic [1:0] bresp, rresp, psel;
  wire logic [31:0] rdata;
  wire logic [8:0] dac;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  sdl_link_if lk();
  assign {lk.sign_n, lk.sign_q, lk.sign_nq, lk.sign_nbq} = sg;
  sdl_ctrl #(.WAIT_CYC(5)) sdl_ctrl_i (.I_CLK(clk), .I_RESET(rst), .LINK(lk), .I_AWADDR(awa),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv),
    .O_WREADY(wr_r), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara),
    .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv),
    .I_RREADY(rr));
  sdl_device #(.DIVIDER_VARIANT(1'b0)) sdl_device_i (.I_CLK(clk), .I_RESET(rst), .LINK(lk),
    .O_DAC_CODE(dac), .O_SWITCH_CLOSED(sw), .O_INTEGRATOR_CLAMP(clamp), .O_POS_SEL(psel),
    .O_POS_HELD(held));
  sdl_link_properties #(.DIVIDER_VARIANT(1'b0)) sdl_link_properties_i (.I_CLK(clk),
    .I_RESET(rst), .word(lk.word), .latch_en(lk.latch_en), .dir_up(lk.dir_up),
    .seek(lk.seek), .ref_clk(lk.ref_clk), .sign_n(lk.sign_n), .sign_q(lk.sign_q),
    .sign_nq(lk.sign_nq), .sign_nbq(lk.sign_nbq), .track_fine(lk.track_fine),
    .track_middle(lk.track_middle), .track_upper(lk.track_upper));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit da, dw;
    da = 0;
    dw = 0;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    while (!(da && dw)) begin
      @(posedge clk);
      if (!da && awr) begin
        awv <= 1'h0;
        da = 1;
      end
      if (!dw && wr_r) begin
        wv <= 1'h0;
        dw = 1;
      end
    end
    br <= 1'h1;
    do @(posedge clk); while (!bv);
    rsp = bresp;
    br <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    ara <= a;
    arv <= 1'h1;
    do @(posedge clk); while (!arr);
    arv <= 1'h0;
    rr <= 1'h1;
    do @(posedge clk); while (!rv);
    rd_q = rdata;
    rsp = rresp;
    rr <= 1'h0;
  endtask
  task automatic settle;
    repeat (16) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    rst = 1'h1;
    {awv, wv, br, arv, rr} = 5'h00;
    {awa, ara, sg} = 12'h000;
    ws = 4'hF;
    wd = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk({lk.seek, lk.dir_up, lk.word}, 32'h300);
    chk(dac, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(SDL_ADDR_CMD, cmds[i]);
      rd(SDL_ADDR_STAT);
      chk(rd_q[4:3], 2'h0);
      settle();
      chk(lk.word, cmds[i][7:0]);
      chk(dac, cmds[i][7:0] == 8'h00 ? 32'h0 : {cmds[i][8], cmds[i][7:0]});
      chk({sw, clamp, held}, {3{~cmds[i][9]}});
      rd(SDL_ADDR_CMD);
      chk(rd_q, {22'h0, cmds[i][9:0]});
      rd(SDL_ADDR_STAT);
      chk(rd_q[4:3], 2'h3);
    end
    wr(4'h8, 32'h0);
    chk(rsp, SDL_RESP_ERR);
    settle();
    chk(lk.word, 8'hFF);
    rd(4'hC);
    chk(rsp, SDL_RESP_ERR);
    for (int s = 0; s < 16; s++) begin
      sg <= s[3:0];
      repeat (12) @(posedge clk);
      chk({lk.track_upper, lk.track_middle, lk.track_fine}, {s[1], s[0], ^s[3:0]});
      rd(SDL_ADDR_STAT);
      chk(rd_q[2:0], {s[1], s[0], ^s[3:0]});
    end
    sg <= 4'h0;
    settle();
    chk(psel, SDL_SEL_N);
    wr(SDL_ADDR_CMD, 32'h000);
    settle();
    sg <= 4'h4;
    settle();
    chk({held, psel}, {1'h1, SDL_SEL_N});
    wr(SDL_ADDR_CMD, 32'h200);
    settle();
    chk({held, psel}, {1'h0, SDL_SEL_Q});
    ws <= 4'h2;
    wr(SDL_ADDR_CMD, 32'h3FF);
    ws <= 4'hF;
    settle();
    rd(SDL_ADDR_CMD);
    chk(rd_q, 32'h300);
    chk(lk.word, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
